// File: rtl/spo_defines.svh
// Constants for the servo PID output offset stage
`ifndef SPO_DEFINES_SVH
`define SPO_DEFINES_SVH

// Register byte addresses
`define SPO_A_PROP 8'h00
`define SPO_A_DERIV 8'h04
`define SPO_A_VFF 8'h08
`define SPO_A_INTEG 8'h0C
`define SPO_A_IMODE 8'h10
`define SPO_A_ILIMIT 8'h14
`define SPO_A_OLIMIT 8'h18
`define SPO_A_OFF1 8'h1C
`define SPO_A_OFF2 8'h20
`define SPO_A_COMMUT 8'h24
`define SPO_A_OUTMODE 8'h28
`define SPO_A_ADCADDR 8'h2C
`define SPO_A_CTRL 8'h30
`define SPO_A_AUX59 8'h34
`define SPO_A_STATUS 8'h38
`define SPO_A_INTVAL 8'h3C
`define SPO_A_EFFORT 8'h40
`define SPO_A_ESA_BASE 8'h80
`define SPO_ESA_COUNT 29
`define SPO_ESA_LAST 8'hF0

// Reset values
`define SPO_RST_PROP 24'h0007D0
`define SPO_RST_DERIV 24'h000500
`define SPO_RST_VFF 24'h000500
`define SPO_RST_INTEG 24'h000000
`define SPO_RST_IMODE 1'b1
`define SPO_RST_ILIMIT 24'h000000
`define SPO_RST_OLIMIT 16'h7FFF
`define SPO_RST_OFF 16'h0000

// Field positions
`define SPO_SIGNMAG_BIT 16
`define SPO_COMMUT_BIT 0
`define SPO_CTRL_ESA_BIT 0
`define SPO_CTRL_NEW_BIT 1

// Scaling of gain products down to 16-bit output weight
`define SPO_GAIN_SHIFT 13
`define SPO_INT_SHIFT 21
`define SPO_PHASE_SHIFT 15
`define SPO_ADC_WIDTH 12
`define SPO_MAX16 17'sh07FFF
`define SPO_MIN16 17'sh18000

`endif

// File: rtl/spo_pkg.sv
// Types shared by the servo output stage
package spo_pkg;

  typedef struct packed {
    logic signed [31:0] cmd_pos;
    logic signed [31:0] act_pos;
    logic signed [31:0] act_vel;
    logic signed [31:0] des_vel;
  } spo_motion_t;

  typedef struct packed {
    logic signed [23:0] kp;
    logic signed [23:0] kd;
    logic [23:0] kff;
    logic [23:0] ki;
    logic imode;
    logic [23:0] ilimit;
    logic [15:0] olimit;
  } spo_gains_t;

endpackage : spo_pkg

// File: rtl/spo_pid_core.sv
// PID plus velocity feedforward effort with limited integrator
`timescale 1ns/1ns
`include "spo_defines.svh"
module spo_pid_core import spo_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Servo cycle request and inputs
  input wire logic tick,
  input wire spo_motion_t mot,
  input wire spo_gains_t g,
  // Result
  output logic signed [15:0] effort,
  output logic done,
  output logic signed [31:0] integ,
  output logic saturated,
  output logic int_hold
);

  logic signed [32:0] err;
  logic signed [63:0] sum;
  logic signed [63:0] iterm;
  logic signed [63:0] total;
  logic signed [63:0] lim;
  logic signed [63:0] next_integ;
  logic signed [63:0] ilim;
  logic hold;

  always_comb begin
    err = 33'(mot.cmd_pos) - 33'(mot.act_pos);
    sum = 64'(g.kp) * 64'(err)
        - 64'(g.kd) * 64'(mot.act_vel)
        + $signed({40'h0000000000, g.kff}) * 64'(mot.des_vel);
    iterm = $signed({40'h0000000000, g.ki}) * 64'(integ);
    // P, D and feedforward products are shifted only after summing; the integral product is shifted on its own
    total = (sum >>> `SPO_GAIN_SHIFT) + (iterm >>> `SPO_INT_SHIFT);
    lim = $signed({48'h000000000000, g.olimit});
    ilim = $signed({40'h0000000000, g.ilimit});
    // Hold on saturation, or on a commanded move in mode 1
    hold = saturated || (g.imode && (mot.des_vel != 32'sh00000000));
    next_integ = hold ? 64'(integ) : 64'(integ) + 64'(err);
    // Zero limit clamps the integrator to zero, so it adds nothing
    if (next_integ > ilim) begin
      next_integ = ilim;
    end else if (next_integ < -ilim) begin
      next_integ = -ilim;
    end
    if (total > lim) begin
      total = lim;
    end else if (total < -lim) begin
      total = -lim;
    end
  end

  // Gains are sampled live at each tick, so rewrites apply next cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      effort <= 16'sh0000;
      integ <= 32'sh00000000;
      saturated <= 1'b0;
      int_hold <= 1'b0;
    end else if (tick) begin
      effort <= total[15:0];
      integ <= next_integ[31:0];
      saturated <= (total == lim) || (total == -lim);
      int_hold <= hold;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= tick;
    end
  end

endmodule : spo_pid_core

// File: rtl/spo_servo_top.sv
// Servo output stage: PID effort, output offsets and phase current offsets
// Function
// - Non-commutated motor: add signed offset to single command before writing output.
// - Sign-magnitude mode: first offset before absolute value, second after.
// - Commutated, open current loop: offsets added to phase A and B commands.
// - Newer variant A->channel A; older variant A->higher DAC, B->lower.
// - Offsets are signed 16-bit, default zero, always 16-bit weighted.
// - Closed current loop: offsets added to ADC readings fetched at address minus one.
// - Narrow ADC readings aligned to 16-bit weight before offset is summed.
// - Proportional term from commanded minus actual position; gain default 2000.
// - Negative proportional gain inverts output or shifts commutation phase 180 degrees.
// - Subtract derivative gain times measured velocity; default 1280.
// - Add velocity feedforward gain times desired velocity; default 1280.
// - Add integral gain times integrated error, limited by integration limit.
// - Zero integration limit gives zero integrator contribution.
// - Integrator holds on output saturation and, in mode 1, during moves.
// - Gains writable anytime; effective on following servo cycles.
// - Extended algorithm reinterprets gain settings 30 through 58.
// - Extended algorithm ignores settings 59 and 63 through 67.
// - Integration mode 1 integrates only at zero desired velocity; mode 0 at any velocity.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "spo_defines.svh"
module spo_servo_top import spo_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Servo cycle inputs
  input wire logic servo_tick,
  input wire spo_motion_t mot,
  input wire logic signed [15:0] sin_a,
  input wire logic signed [15:0] sin_b,
  input wire logic signed [15:0] esa_effort,
  // Phase current ADC pins
  input wire logic [`SPO_ADC_WIDTH-1:0] adc_pin_a,
  input wire logic [`SPO_ADC_WIDTH-1:0] adc_pin_b,
  output logic [23:0] adc_fetch_addr,
  // DAC and current loop outputs
  output logic signed [15:0] dac_ch0,
  output logic signed [15:0] dac_ch1,
  output logic dac_sign,
  output logic [15:0] out_addr,
  output logic dac_valid,
  output logic signed [15:0] cur_fb_a,
  output logic signed [15:0] cur_fb_b,
  output logic cur_valid
);

  logic signed [23:0] prop_gain;
  logic signed [23:0] deriv_gain;
  logic [23:0] vff_gain;
  logic [23:0] int_gain;
  logic int_mode;
  logic [23:0] int_limit;
  logic [15:0] out_limit;
  logic signed [15:0] first_phase_output_offset;
  logic signed [15:0] second_phase_output_offset;
  logic [23:0] commutation_select;
  logic [23:0] output_address_and_mode;
  logic [23:0] current_loop_adc_address;
  logic [1:0] ctrl;
  logic [23:0] pid_aux_setting_59;
  logic [23:0] esa_gain [`SPO_ESA_COUNT];
  logic esa_hit;
  logic [7:0] esa_off;
  logic [4:0] esa_idx;
  spo_gains_t gains;
  logic signed [15:0] pid_effort;
  logic pid_done;
  logic signed [31:0] integ;
  logic saturated;
  logic int_hold;
  logic extended_servo_algorithm;
  logic newer_variant;
  logic commutating;
  logic loop_closed;
  logic sign_mag;
  logic signed [15:0] effort;
  logic signed [15:0] ph_a;
  logic signed [15:0] ph_b;
  logic signed [31:0] prod_a;
  logic signed [31:0] prod_b;
  logic signed [16:0] pre_abs;
  logic signed [16:0] mag;
  logic signed [15:0] next_ch0;
  logic signed [15:0] next_ch1;
  logic signed [15:0] next_fb_a;
  logic signed [15:0] next_fb_b;
  logic [`SPO_ADC_WIDTH-1:0] adc_a_s1;
  logic [`SPO_ADC_WIDTH-1:0] adc_a_s2;
  logic [`SPO_ADC_WIDTH-1:0] adc_b_s1;
  logic [`SPO_ADC_WIDTH-1:0] adc_b_s2;
  logic signed [15:0] adc_a16;
  logic signed [15:0] adc_b16;

  function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
    if (v > `SPO_MAX16) begin
      sat16 = 16'sh7FFF;
    end else if (v < `SPO_MIN16) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // Configuration writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prop_gain <= `SPO_RST_PROP;
      deriv_gain <= `SPO_RST_DERIV;
      vff_gain <= `SPO_RST_VFF;
      int_gain <= `SPO_RST_INTEG;
      int_mode <= `SPO_RST_IMODE;
      int_limit <= `SPO_RST_ILIMIT;
      out_limit <= `SPO_RST_OLIMIT;
      first_phase_output_offset <= `SPO_RST_OFF;
      second_phase_output_offset <= `SPO_RST_OFF;
      commutation_select <= 24'h000000;
      output_address_and_mode <= 24'h000000;
      current_loop_adc_address <= 24'h000000;
      ctrl <= 2'h0;
      pid_aux_setting_59 <= 24'h000000;
    end else if (wr) begin
      case (addr)
        `SPO_A_PROP: prop_gain <= wdata[23:0];
        `SPO_A_DERIV: deriv_gain <= wdata[23:0];
        `SPO_A_VFF: vff_gain <= {1'b0, wdata[22:0]};
        `SPO_A_INTEG: int_gain <= {1'b0, wdata[22:0]};
        `SPO_A_IMODE: int_mode <= wdata[0];
        `SPO_A_ILIMIT: int_limit <= {1'b0, wdata[22:0]};
        // Output limit kept within the 16-bit positive range
        `SPO_A_OLIMIT: out_limit <= {1'b0, wdata[14:0]};
        `SPO_A_OFF1: first_phase_output_offset <= wdata[15:0];
        `SPO_A_OFF2: second_phase_output_offset <= wdata[15:0];
        `SPO_A_COMMUT: commutation_select <= wdata[23:0];
        `SPO_A_OUTMODE: output_address_and_mode <= wdata[23:0];
        `SPO_A_ADCADDR: current_loop_adc_address <= wdata[23:0];
        `SPO_A_CTRL: ctrl <= wdata[1:0];
        `SPO_A_AUX59: pid_aux_setting_59 <= wdata[23:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Extended-algorithm gain table: alternative meanings of settings 30..58
  assign esa_off = addr - `SPO_A_ESA_BASE;
  assign esa_idx = esa_off[6:2];
  assign esa_hit = (addr >= `SPO_A_ESA_BASE) && (addr <= `SPO_ESA_LAST)
                   && (addr[1:0] == 2'h0);

  generate
    for (genvar i = 0; i < `SPO_ESA_COUNT; i++) begin : g_esa
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          esa_gain[i] <= 24'h000000;
        end else if (wr && esa_hit && (esa_idx == 5'(i))) begin
          esa_gain[i] <= wdata[23:0];
        end
      end
    end
  endgenerate

  // Read port: data in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `SPO_A_PROP: rdata <= {{8{prop_gain[23]}}, prop_gain};
        `SPO_A_DERIV: rdata <= {{8{deriv_gain[23]}}, deriv_gain};
        `SPO_A_VFF: rdata <= {8'h00, vff_gain};
        `SPO_A_INTEG: rdata <= {8'h00, int_gain};
        `SPO_A_IMODE: rdata <= {31'h00000000, int_mode};
        `SPO_A_ILIMIT: rdata <= {8'h00, int_limit};
        `SPO_A_OLIMIT: rdata <= {16'h0000, out_limit};
        `SPO_A_OFF1: rdata <= 32'(first_phase_output_offset);
        `SPO_A_OFF2: rdata <= 32'(second_phase_output_offset);
        `SPO_A_COMMUT: rdata <= {8'h00, commutation_select};
        `SPO_A_OUTMODE: rdata <= {8'h00, output_address_and_mode};
        `SPO_A_ADCADDR: rdata <= {8'h00, current_loop_adc_address};
        `SPO_A_CTRL: rdata <= {30'h00000000, ctrl};
        `SPO_A_AUX59: rdata <= {8'h00, pid_aux_setting_59};
        `SPO_A_STATUS: rdata <= {30'h00000000, int_hold, saturated};
        `SPO_A_INTVAL: rdata <= integ;
        `SPO_A_EFFORT: rdata <= 32'(effort);
        default: rdata <= esa_hit ? {8'h00, esa_gain[esa_idx]} : 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

  assign extended_servo_algorithm = ctrl[`SPO_CTRL_ESA_BIT];
  assign newer_variant = ctrl[`SPO_CTRL_NEW_BIT];
  assign commutating = commutation_select[`SPO_COMMUT_BIT];
  assign loop_closed = current_loop_adc_address != 24'h000000;
  assign sign_mag = output_address_and_mode[`SPO_SIGNMAG_BIT];

  // Extended mode drops the integration limit, leaving no integrator
  always_comb begin
    gains.kp = prop_gain;
    gains.kd = deriv_gain;
    gains.kff = vff_gain;
    gains.ki = int_gain;
    gains.imode = int_mode;
    gains.ilimit = extended_servo_algorithm ? 24'h000000 : int_limit;
    gains.olimit = out_limit;
  end

  spo_pid_core u_core (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(servo_tick),
    .mot(mot),
    .g(gains),
    .effort(pid_effort),
    .done(pid_done),
    .integ(integ),
    .saturated(saturated),
    .int_hold(int_hold)
  );

  // External algorithm supplies its own effort when selected
  assign effort = extended_servo_algorithm ? esa_effort : pid_effort;

  // Sign of effort carries a negative proportional gain into both paths
  always_comb begin
    prod_a = 32'(effort) * 32'(sin_a);
    prod_b = 32'(effort) * 32'(sin_b);
    ph_a = prod_a[15 + `SPO_PHASE_SHIFT:`SPO_PHASE_SHIFT];
    ph_b = prod_b[15 + `SPO_PHASE_SHIFT:`SPO_PHASE_SHIFT];
    pre_abs = 17'(effort) + 17'(first_phase_output_offset);
    mag = pre_abs[16] ? -pre_abs : pre_abs;
    next_ch0 = sat16(17'(effort) + 17'(first_phase_output_offset));
    next_ch1 = 16'sh0000;
    if (commutating) begin
      if (newer_variant) begin
        next_ch0 = sat16(17'(ph_a) + 17'(first_phase_output_offset));
        next_ch1 = sat16(17'(ph_b) + 17'(second_phase_output_offset));
      end else begin
        next_ch1 = sat16(17'(ph_a) + 17'(first_phase_output_offset));
        next_ch0 = sat16(17'(ph_b) + 17'(second_phase_output_offset));
      end
    end else if (sign_mag) begin
      next_ch0 = sat16(mag + 17'(second_phase_output_offset));
    end
  end

  // Outputs written one cycle after the effort settles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dac_ch0 <= 16'sh0000;
      dac_ch1 <= 16'sh0000;
      dac_sign <= 1'b0;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= pid_done && !(commutating && loop_closed);
      if (pid_done && !(commutating && loop_closed)) begin
        dac_ch0 <= next_ch0;
        dac_ch1 <= next_ch1;
        dac_sign <= !commutating && sign_mag && pre_abs[16];
      end
    end
  end

  assign out_addr = output_address_and_mode[15:0];

  // ADC pins cross into the clock domain through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adc_a_s1 <= '0;
      adc_a_s2 <= '0;
      adc_b_s1 <= '0;
      adc_b_s2 <= '0;
    end else begin
      adc_a_s1 <= adc_pin_a;
      adc_a_s2 <= adc_a_s1;
      adc_b_s1 <= adc_pin_b;
      adc_b_s2 <= adc_b_s1;
    end
  end

  // Narrow reading moved up to 16-bit weight
  assign adc_a16 = {adc_a_s2, {(16 - `SPO_ADC_WIDTH){1'b0}}};
  assign adc_b16 = {adc_b_s2, {(16 - `SPO_ADC_WIDTH){1'b0}}};
  assign next_fb_a = sat16(17'(adc_a16) + 17'(first_phase_output_offset));
  assign next_fb_b = sat16(17'(adc_b16) + 17'(second_phase_output_offset));

  // Phase A reading sits one below the configured address
  assign adc_fetch_addr = current_loop_adc_address - 24'h000001;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_fb_a <= 16'sh0000;
      cur_fb_b <= 16'sh0000;
      cur_valid <= 1'b0;
    end else begin
      cur_valid <= pid_done && commutating && loop_closed;
      if (pid_done && commutating && loop_closed) begin
        cur_fb_a <= next_fb_a;
        cur_fb_b <= next_fb_b;
      end
    end
  end

endmodule : spo_servo_top

// File: bench/spo_servo_chk.sv
// Port-level assertions for the servo output stage
`timescale 1ns/1ns
`include "spo_defines.svh"
module spo_servo_chk import spo_pkg::*; (
  // Clock, reset and register port
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Servo cycle and outputs
  input wire logic servo_tick,
  input wire logic [23:0] adc_fetch_addr,
  input wire logic signed [15:0] dac_ch0,
  input wire logic signed [15:0] dac_ch1,
  input wire logic [15:0] out_addr,
  input wire logic dac_valid,
  input wire logic signed [15:0] cur_fb_a,
  input wire logic signed [15:0] cur_fb_b,
  input wire logic cur_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence seq_tick;
    servo_tick;
  endsequence
  sequence seq_result;
    ##2 (dac_valid || cur_valid);
  endsequence
  sequence seq_off_wr;
    wr && addr == `SPO_A_OFF1;
  endsequence
  AST_RESULT_LATENCY: assert property (seq_tick |-> seq_result)
    else $error("no result two cycles after tick");
  AST_RESULT_CAUSE: assert property ((dac_valid || cur_valid) |-> $past(servo_tick, 2))
    else $error("result without a tick");
  AST_ONE_PATH: assert property (!(dac_valid && cur_valid))
    else $error("dac and current paths updated together");
  AST_DAC_HOLD: assert property (!dac_valid |-> $stable(dac_ch0) && $stable(dac_ch1))
    else $error("dac output moved without update");
  AST_CUR_HOLD: assert property (!cur_valid |-> $stable({cur_fb_a, cur_fb_b}))
    else $error("current feedback moved without update");
  AST_FETCH_ADDR: assert property (wr && addr == `SPO_A_ADCADDR |=>
    adc_fetch_addr == $past(wdata[23:0]) - 24'h000001)
    else $error("adc fetch address not one below setting");
  AST_OUT_ADDR: assert property (wr && addr == `SPO_A_OUTMODE |=>
    out_addr == $past(wdata[15:0]))
    else $error("output address not taken from mode word");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_OFF_READBACK: assert property (seq_off_wr ##1 (rd && addr == `SPO_A_OFF1) |=>
    rdata[15:0] == $past(wdata[15:0], 2))
    else $error("offset readback differs from write");
endmodule : spo_servo_chk

bind spo_servo_top spo_servo_chk i_chk (.mclk(mclk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .servo_tick(servo_tick),
  .adc_fetch_addr(adc_fetch_addr), .dac_ch0(dac_ch0), .dac_ch1(dac_ch1), .out_addr(out_addr),
  .dac_valid(dac_valid), .cur_fb_a(cur_fb_a), .cur_fb_b(cur_fb_b), .cur_valid(cur_valid));

// File: bench/spo_amp_model.sv
// Amplifier model: phase capture from the DACs and phase current ADC source
`timescale 1ns/1ns
`include "spo_defines.svh"
module spo_amp_model (
  // Clock and variant
  input wire logic mclk,
  input wire logic newer,
  // Current sensing
  input wire logic [`SPO_ADC_WIDTH-1:0] lvl_a,
  input wire logic [`SPO_ADC_WIDTH-1:0] lvl_b,
  output logic [`SPO_ADC_WIDTH-1:0] adc_pin_a,
  output logic [`SPO_ADC_WIDTH-1:0] adc_pin_b,
  // Command capture
  input wire logic signed [15:0] dac_ch0,
  input wire logic signed [15:0] dac_ch1,
  input wire logic dac_valid,
  output logic signed [15:0] phase_a,
  output logic signed [15:0] phase_b
);
  // Converters run free, so the block must synchronise them
  assign adc_pin_a = lvl_a;
  assign adc_pin_b = lvl_b;
  always_ff @(posedge mclk) begin
    if (dac_valid) begin
      phase_a <= newer ? dac_ch0 : dac_ch1;
      phase_b <= newer ? dac_ch1 : dac_ch0;
    end
  end
endmodule : spo_amp_model

// File: bench/spo_servo_top_tb.sv
// Self-checking bench for the servo output stage
`timescale 1ns/1ns
`include "spo_defines.svh"
module spo_servo_top_tb import spo_pkg::*; ;
  typedef struct {
    logic signed [23:0] kp;
    logic signed [31:0] err, av, dv;
    logic signed [15:0] off, exp;
  } spo_row_t;
  logic mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, servo_tick = 1'b0, newer = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  spo_motion_t mot = '0;
  logic signed [15:0] sin_a = 16'h0, sin_b = 16'h0, esa_effort = 16'h0, ph_a, ph_b;
  logic [`SPO_ADC_WIDTH-1:0] lvl_a = 12'hFFB, lvl_b = 12'h010, pin_a, pin_b;
  logic [23:0] fetch;
  logic signed [15:0] ch0, ch1, fb_a, fb_b;
  logic sgn, dvalid, cvalid;
  logic [15:0] oaddr;
  int num_errors = 0, check_count = 0;
  spo_row_t rows [7];
  logic [7:0] dflt_a [10] = '{`SPO_A_PROP, `SPO_A_DERIV, `SPO_A_VFF, `SPO_A_INTEG,
    `SPO_A_IMODE, `SPO_A_ILIMIT, `SPO_A_OLIMIT, `SPO_A_OFF1, `SPO_A_OFF2, 8'h50};
  logic [31:0] dflt_v [10] = '{32'h7D0, 32'h500, 32'h500, 32'h0, 32'h1, 32'h0, 32'h7FFF,
    32'h0, 32'h0, 32'h0};

  spo_servo_top i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .servo_tick(servo_tick), .mot(mot), .sin_a(sin_a), .sin_b(sin_b),
    .esa_effort(esa_effort), .adc_pin_a(pin_a), .adc_pin_b(pin_b), .adc_fetch_addr(fetch),
    .dac_ch0(ch0), .dac_ch1(ch1), .dac_sign(sgn), .out_addr(oaddr), .dac_valid(dvalid),
    .cur_fb_a(fb_a), .cur_fb_b(fb_b), .cur_valid(cvalid));
  spo_amp_model i_amp (.mclk(mclk), .newer(newer), .lvl_a(lvl_a), .lvl_b(lvl_b),
    .adc_pin_a(pin_a), .adc_pin_b(pin_b), .dac_ch0(ch0), .dac_ch1(ch1), .dac_valid(dvalid),
    .phase_a(ph_a), .phase_b(ph_b));

  initial begin
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Write strobe stays up for a back-to-back write; next read or tick lowers it
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
  endtask : wreg

  // Read data taken at the edge that closes the cycle in which it stands
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask : rreg

  // Offset positions keep the subtraction of actual from commanded in play
  task automatic cyc(input logic signed [31:0] err, av, dv);
    mot <= '{err + 32'sh3E8, 32'sh3E8, av, dv};
    wr <= 1'b0;
    servo_tick <= 1'b1;
    @(posedge mclk);
    servo_tick <= 1'b0;
    // Core edge, then output edge; valid is read while it stands
    repeat (2) @(posedge mclk);
    chk("valid", 32'h1, {31'h0, dvalid | cvalid});
  endtask : cyc

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Whole run is under two hundred cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    conclude();
  end

  initial begin
    rows = '{'{2000, 4096, 0, 0, 0, 1000}, '{2000, 4096, 0, 0, -100, 900},
      '{-2000, 4096, 0, 0, 0, -1000}, '{2000, 0, 64, 0, 0, -10}, '{2000, 0, 0, 64, 0, 10},
      '{2000, 1048576, 0, 0, 100, 32767}, '{2000, -1048576, 0, 0, -100, -32768}};
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("fetch", 32'h00FFFFFF, {8'h0, fetch});
    wreg(8'h50, 32'hFFFFFFFF);
    foreach (dflt_a[i]) begin
      rreg(dflt_a[i], rv);
      chk("default", dflt_v[i], rv);
    end
    foreach (rows[i]) begin
      wreg(`SPO_A_PROP, 32'(rows[i].kp));
      wreg(`SPO_A_OFF1, 32'(rows[i].off));
      rreg(`SPO_A_OFF1, rv);
      chk("off1", 32'({16'h0, rows[i].off}), {16'h0, rv[15:0]});
      cyc(rows[i].err, rows[i].av, rows[i].dv);
      chk("ch0", 32'(rows[i].exp), 32'(ch0));
      chk("ch1", 32'h0, 32'(ch1));
    end
    wreg(`SPO_A_OUTMODE, 32'h00010003);
    wreg(`SPO_A_OFF1, 32'hFFFFFBB4);
    wreg(`SPO_A_OFF2, 32'h00000032);
    cyc(4096, 0, 0);
    chk("signmag", 32'h00000096, 32'(ch0));
    chk("sign", 32'h1, {31'h0, sgn});
    chk("out_addr", 32'h00000003, {16'h0, oaddr});
    wreg(`SPO_A_OUTMODE, 32'h0);
    wreg(`SPO_A_COMMUT, 32'h1);
    wreg(`SPO_A_OFF1, 32'h0000000A);
    wreg(`SPO_A_OFF2, 32'h00000014);
    sin_a <= 16'h4000;
    sin_b <= 16'hC000;
    for (int v = 1; v >= 0; v--) begin
      newer <= v[0];
      wreg(`SPO_A_CTRL, {30'h0, v[0], 1'b0});
      cyc(4096, 0, 0);
      chk("ch0", v ? 32'h000001FE : 32'hFFFFFE20, 32'(ch0));
      @(posedge mclk);
      chk("phase_a", 32'h000001FE, 32'(ph_a));
      chk("phase_b", 32'hFFFFFE20, 32'(ph_b));
    end
    wreg(`SPO_A_ADCADDR, 32'h00000005);
    wreg(`SPO_A_OFF1, 32'h00000050);
    chk("fetch", 32'h00000004, {8'h0, fetch});
    wreg(`SPO_A_OFF2, 32'hFFFFFFFA);
    cyc(4096, 0, 0);
    chk("cur_a", 32'h0, 32'(fb_a));
    chk("cur_b", 32'h000000FA, 32'(fb_b));
    wreg(`SPO_A_ADCADDR, 32'h0);
    wreg(`SPO_A_COMMUT, 32'h0);
    wreg(`SPO_A_PROP, 32'h0);
    wreg(`SPO_A_IMODE, 32'h0);
    wreg(`SPO_A_ILIMIT, 32'h000003E8);
    repeat (4) cyc(300, 0, 0);
    rreg(`SPO_A_INTVAL, rv);
    chk("integ", 32'h000003E8, rv);
    // Integral term alone: 8192 * 1000 >>> 21 = 3, plus offset 80
    wreg(`SPO_A_INTEG, 32'h00002000);
    cyc(0, 0, 0);
    chk("iterm", 32'h00000053, 32'(ch0));
    wreg(`SPO_A_IMODE, 32'h1);
    cyc(-300, 0, 64);
    rreg(`SPO_A_INTVAL, rv);
    chk("integ", 32'h000003E8, rv);
    cyc(-300, 0, 0);
    rreg(`SPO_A_INTVAL, rv);
    chk("integ", 32'h000002BC, rv);
    wreg(`SPO_A_ILIMIT, 32'h0);
    cyc(-300, 0, 0);
    rreg(`SPO_A_INTVAL, rv);
    chk("integ", 32'h0, rv);
    wreg(`SPO_A_CTRL, 32'h1);
    esa_effort <= 16'h04D2;
    wreg(`SPO_A_OFF1, 32'h0);
    wreg(`SPO_A_ILIMIT, 32'h000003E8);
    cyc(300, 0, 0);
    chk("esa", 32'h000004D2, 32'(ch0));
    rreg(`SPO_A_INTVAL, rv);
    chk("esa_integ", 32'h0, rv);
    wreg(`SPO_ESA_LAST, 32'h00123456);
    rreg(`SPO_ESA_LAST, rv);
    chk("esa_gain", 32'h00123456, rv);
    rst_n <= 1'b0;
    @(posedge mclk);
    chk("reset", 32'h0, 32'(ch0));
    rst_n <= 1'b1;
    @(posedge mclk);
    rreg(`SPO_A_PROP, rv);
    chk("prop_reset", 32'h000007D0, rv);
    rreg(`SPO_A_CTRL, rv);
    chk("ctrl_reset", 32'h0, rv);
    conclude();
  end
endmodule : spo_servo_top_tb
